/* bench/bcx_core_sva.sv */
// bcx_core_sva: port checks for the executor core
// assumes one clock domain, reset and ce as the design sees them
`timescale 1ns/1ps
module bcx_core_sva
	import bcx_pkg::*;
(
	// clock and reset
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        ce,
	// bus
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	// core side
	input wire logic [20:0] prog_addr,
	input wire bcx_dwr_t    dmem_wr
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst || !ce);
	AST_BUS_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait");
	AST_BUS_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	AST_BUS_REARM: assert property (!avs_waitrequest && (avs_read || avs_write)
		|=> avs_waitrequest || !(avs_read || avs_write)) else $error("double accept");
	AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without read");
	AST_CLR_ZERO: assert property (dmem_wr.we |-> dmem_wr.data == BCX_CLR_VALUE)
		else $error("clear wrote nonzero");
	AST_CLR_ONE_Q: assert property (dmem_wr.we |=> !dmem_wr.we [*3])
		else $error("more than one write per cycle");
	AST_PC_EVEN: assert property (!prog_addr[0])
		else $error("odd fetch address");
	AST_RST_STATE: assert property ($fell(rst) |-> prog_addr == BCX_PC_RST && !dmem_wr.we)
		else $error("bad state after reset");
	cover property (dmem_wr.we);
	cover property (avs_read && !avs_waitrequest);
	cover property (avs_write && !avs_waitrequest);
endmodule // bcx_core_sva

/* bench/bcx_core_test.sv */
// bcx_core_test: row-driven bench for the executor core
// assumes program memory model loaded by the bench, ce and lanes held on
`timescale 1ns/1ps
module bcx_core_test
	import bcx_pkg::*;
;
	typedef struct packed {
		logic [11:0] pc0;
		logic [15:0] w1;
		logic [15:0] w2;
		logic [4:0]  st;
		logic [2:0]  ctl;
		logic [11:0] tgt;
		logic [11:0] wa;
	} bcx_row_t;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [20:0] prog_addr;
	logic [15:0] prog_data;
	bcx_dwr_t    dmem_wr;
	logic [31:0] rd;
	int          bad_count = 0;
	int          total_checks = 0;
	// marker clears: f81 fall-through, f82 branch target
	bcx_row_t    rows [12] = '{
		'{12'h040,16'hE403,16'h6A81,5'h08,3'h1,12'h048,12'hF82},
		'{12'h060,16'hE403,16'h6A81,5'h04,3'h1,12'h068,12'hF81},
		'{12'h080,16'hE0FC,16'h6A81,5'h04,3'h1,12'h07A,12'hF82},
		'{12'h0A0,16'hE0FC,16'h6A81,5'h1B,3'h1,12'h09A,12'hF81},
		'{12'h0C0,16'hE07F,16'h6A81,5'h04,3'h1,12'h1C0,12'hF82},
		'{12'h200,16'hE080,16'h6A81,5'h1F,3'h1,12'h102,12'hF82},
		'{12'h120,16'h6B33,16'h0000,5'h00,3'h1,12'h700,12'h533},
		'{12'h140,16'h6A90,16'h0000,5'h11,3'h1,12'h700,12'hF90},
		'{12'h160,16'h6A20,16'h0000,5'h00,3'h1,12'h700,12'h020},
		'{12'h180,16'h6A5F,16'h0000,5'h00,3'h3,12'h700,12'h35F},
		'{12'h1A0,16'h6A60,16'h0000,5'h00,3'h3,12'h700,12'h060},
		'{12'h0E0,16'hEDF0,16'hF000,5'h1F,3'h1,12'h1E0,12'hF82}
	};
	always #5 clock = ~clock;
	bcx_core #(.POST_LAST(8'h00)) u_dut (.clock(clock), .rst(rst), .ce(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr), .prog_data(prog_data),
		.dmem_wr(dmem_wr));
	bcx_prog_mem u_pm (.prog_addr(prog_addr), .prog_data(prog_data));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held up to the rising edge that samples waitrequest low, data taken there
	// one idle edge between calls so no strobe is written twice in one step
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
		if (n >= 50) bad_count++;
	endtask
	task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask
	// halting waits out the instruction in flight; a pending idle cycle is kept and runs after the restart
	task automatic halt_core;
		bus(1'b1, BCX_REG_CTRL, 32'h0000_0000);
		repeat (12) @(posedge clock);
	endtask
	task automatic start_at(input logic [11:0] pc, input logic [2:0] ctl);
		int n;
		n = 0;
		bus(1'b1, BCX_REG_PC, {20'h0_0000, pc});
		bus(1'b1, BCX_REG_CTRL, {29'h0000_0000, ctl});
		do begin
			@(posedge clock);
			n++;
		end while (dmem_wr.we !== 1'b1 && n < 200);
		if (n >= 200) bad_count++;
	endtask
	task automatic run_row(input bcx_row_t r);
		halt_core();
		u_pm.mem[r.pc0[10:1]] = r.w1;
		u_pm.mem[r.pc0[10:1] + 10'd1] = r.w2;
		u_pm.mem[r.pc0[10:1] + 10'd2] = 16'h6A81;
		u_pm.mem[r.tgt[10:1]] = 16'h6A82;
		bus(1'b1, BCX_REG_STATUS, {27'h000_0000, r.st});
		start_at(r.pc0, r.ctl);
		chk("dmem_addr", {20'h0_0000, r.wa}, {20'h0_0000, dmem_wr.addr});
		@(posedge clock);
		halt_core();
		rd_chk("status", BCX_REG_STATUS, {27'h000_0000, r.st | 5'h04});
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clock);
		bad_count++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd_chk("wdt_rst", BCX_REG_WDT, 32'h0003_0000);
		bus(1'b1, BCX_REG_TOS, 32'h0000_0123);
		rd_chk("tos_ro", BCX_REG_TOS, 32'h0000_0000);
		rd_chk("unmapped", 6'h3C, 32'h0000_0000);
		bus(1'b1, BCX_REG_W, 32'h0000_00A5);
		bus(1'b1, BCX_REG_BSR, 32'h0000_0005);
		bus(1'b1, BCX_REG_FSR2, 32'h0000_0300);
		foreach (rows[i]) run_row(rows[i]);
		rd_chk("tos", BCX_REG_TOS, 32'h0000_00E4);
		rd_chk("shadow", BCX_REG_SHADOW, 32'h0005_1FA5);
		// free-running no-ops with the watchdog on, past its 256-cycle span
		bus(1'b1, BCX_REG_PC, 32'h0000_0400);
		bus(1'b1, BCX_REG_CTRL, 32'h0000_0005);
		repeat (1200) @(posedge clock);
		bus(1'b0, BCX_REG_WDT, 32'h0000_0000);
		chk("expiry", 32'h0000_0000, {31'h0000_0000, rd[16]});
		halt_core();
		u_pm.mem[10'h300] = 16'h0004;
		u_pm.mem[10'h301] = 16'h6A81;
		start_at(12'h600, 3'h1);
		@(posedge clock);
		halt_core();
		rd_chk("wdt_kick", BCX_REG_WDT, 32'h0003_0000);
		test_done();
	end
endmodule // bcx_core_test
bind bcx_core bcx_core_sva u_sva (.clock(clock), .rst(rst), .ce(ce), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
	.prog_addr(prog_addr), .dmem_wr(dmem_wr));

/* bench/bcx_prog_mem.sv */
// bcx_prog_mem: program memory answering the fetch address at once
// assumes the bench loads words by hierarchical writes to mem
`timescale 1ns/1ps
module bcx_prog_mem (
	// fetch port
	input  wire logic [20:0] prog_addr,
	output logic      [15:0] prog_data
);
	logic [15:0] mem [1024];
	// unloaded words run as no-ops
	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
	end
	// outside the array data flips with the address, never a stale word
	assign prog_data = (prog_addr[20:11] == 10'h000) ? mem[prog_addr[10:1]]
		: ~prog_addr[16:1];
endmodule // bcx_prog_mem

/* src/bcx_core.sv */
// bcx_core: four-phase executor for relative branches, call, register clear, watchdog kick
// assumes program memory answers combinationally to prog_addr on the same clock
// Behaviour
// - opcode E4 with offset branches only when overflow is one
// - opcode E0 with offset branches only when zero is one
// - taken branch target is incremented pc plus twice signed offset
// - not taken: one cycle; taken: pc written in q4, then idle cycle
// - call is two words: 1110110s low address, then 1111 high bits
// - call pushes call address plus four onto top of stack
// - call with s set copies w, status, bank select into shadows
// - call loads 20-bit literal into pc bits 20 down to 1
// - call: low literal q2, push q3, high literal and pc q4, idle cycle
// - opcode 0110101a clears addressed register, sets zero flag, one cycle
// - a bit zero selects access bank, one selects bank select bank
// - a zero with extended set: addresses up to 5f are indexed
// - opcode 0004 clears watchdog count, sets expiry and sleep flags
// - watchdog kick also clears the postscaler
`timescale 1ns/1ps
module bcx_core
	import bcx_pkg::*;
#(
	parameter logic [7:0] POST_LAST = BCX_POST_DEF
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	// avalon-mm slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// program memory
	output logic      [20:0] prog_addr,
	input  wire logic [15:0] prog_data,
	// data memory write port
	output bcx_dwr_t         dmem_wr
);

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		be_merge = (old & ~m) | (wd & m);
	endfunction

	// bus group
	logic        ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        bus_wr;

	// core group
	bcx_phase_t  phase_ff, nxt_phase;
	logic        nop_ff, nxt_nop;
	logic [15:0] ir_ff, nxt_ir;
	logic [20:0] pc_ff, nxt_pc;
	logic [20:0] tos_ff, nxt_tos;
	logic [7:0]  w_ff, nxt_w;
	bcx_flags_t  st_ff, nxt_st;
	logic [3:0]  bsr_ff, nxt_bsr;
	logic [7:0]  ws_ff, nxt_ws;
	bcx_flags_t  sts_ff, nxt_sts;
	logic [3:0]  bank_select_shadow_ff, nxt_bank_select_shadow;
	logic [11:0] fsr2_ff, nxt_fsr2;
	logic [11:0] daddr_ff, nxt_daddr;
	bcx_dwr_t    dwr_ff, nxt_dwr;
	logic [7:0]  wcnt_ff, nxt_wcnt;
	logic [7:0]  wpost_ff, nxt_wpost;
	logic        exp_ff, nxt_exp;
	logic        slp_ff, nxt_slp;
	logic [2:0]  ctrl_ff, nxt_ctrl;

	// decode
	logic        is_bov, is_bz, is_call, is_zero_register_instr, is_kick, taken;
	logic [20:0] offs;
	logic [31:0] mw;

	assign bus_wr          = avs_write & ack_ff;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata    = rdata_ff;
	assign prog_addr       = pc_ff;
	assign dmem_wr         = dwr_ff;

	assign is_bov  = ir_ff[15:8] == BCX_OP_BOV;
	assign is_bz   = ir_ff[15:8] == BCX_OP_BZ;
	assign is_call = ir_ff[15:9] == BCX_OP_CALL;
	assign is_zero_register_instr = ir_ff[15:9] == BCX_OP_ZERO_REGISTER_INSTR;
	assign is_kick = ir_ff == BCX_OP_WATCHDOG_KICK_INSTR;
	assign taken   = (is_bov & st_ff.ovf) | (is_bz & st_ff.zero);
	// sign-extended 2n; pc already points past the branch word
	assign offs    = {{12{ir_ff[7]}}, ir_ff[7:0], 1'b0};

	// bus: one wait cycle, then answer with registered data
	always_comb begin
		nxt_ack   = (avs_read | avs_write) & ~ack_ff;
		nxt_rdata = rdata_ff;
		if (avs_read & ~ack_ff) begin
			case (avs_address)
				BCX_REG_CTRL:   nxt_rdata = {29'h0, ctrl_ff};
				BCX_REG_PC:     nxt_rdata = {11'h0, pc_ff};
				BCX_REG_W:      nxt_rdata = {24'h0, w_ff};
				BCX_REG_STATUS: nxt_rdata = {24'h0, st_ff};
				BCX_REG_BSR:    nxt_rdata = {28'h0, bsr_ff};
				BCX_REG_SHADOW: nxt_rdata = {12'h0, bank_select_shadow_ff, sts_ff, ws_ff};
				BCX_REG_TOS:    nxt_rdata = {11'h0, tos_ff};
				BCX_REG_WDT:    nxt_rdata = {14'h0, slp_ff, exp_ff, wpost_ff, wcnt_ff};
				BCX_REG_FSR2:   nxt_rdata = {20'h0, fsr2_ff};
				BCX_REG_PHASE:  nxt_rdata = {27'h0, nop_ff, phase_ff};
				default:        nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else if (ce) begin
			ack_ff   <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	// core: bus writes first, then instruction effects so hardware wins a tie
	always_comb begin
		nxt_phase = phase_ff;
		nxt_nop   = nop_ff;
		nxt_ir    = ir_ff;
		nxt_pc    = pc_ff;
		nxt_tos   = tos_ff;
		nxt_w     = w_ff;
		nxt_st    = st_ff;
		nxt_bsr   = bsr_ff;
		nxt_ws    = ws_ff;
		nxt_sts   = sts_ff;
		nxt_bank_select_shadow  = bank_select_shadow_ff;
		nxt_fsr2  = fsr2_ff;
		nxt_daddr = daddr_ff;
		nxt_dwr   = '0;
		nxt_wcnt  = wcnt_ff;
		nxt_wpost = wpost_ff;
		nxt_exp   = exp_ff;
		nxt_slp   = slp_ff;
		nxt_ctrl  = ctrl_ff;
		mw        = 32'h0000_0000;
		if (bus_wr) begin
			case (avs_address)
				BCX_REG_CTRL: begin
					mw       = be_merge({29'h0, ctrl_ff}, avs_writedata, avs_byteenable);
					nxt_ctrl = mw[2:0];
				end
				BCX_REG_PC: begin
					mw     = be_merge({11'h0, pc_ff}, avs_writedata, avs_byteenable);
					nxt_pc = {mw[20:1], 1'b0};
				end
				BCX_REG_W: begin
					mw    = be_merge({24'h0, w_ff}, avs_writedata, avs_byteenable);
					nxt_w = mw[7:0];
				end
				BCX_REG_STATUS: begin
					mw     = be_merge({24'h0, st_ff}, avs_writedata, avs_byteenable);
					nxt_st = {3'b000, mw[4:0]};
				end
				BCX_REG_BSR: begin
					mw      = be_merge({28'h0, bsr_ff}, avs_writedata, avs_byteenable);
					nxt_bsr = mw[3:0];
				end
				BCX_REG_FSR2: begin
					mw       = be_merge({20'h0, fsr2_ff}, avs_writedata, avs_byteenable);
					nxt_fsr2 = mw[11:0];
				end
				default: begin
					mw = 32'h0000_0000;
				end
			endcase
		end
		// halting only takes effect at a cycle boundary, so no instruction is cut in half
		if (ctrl_ff[BCX_CTRL_RUN] || phase_ff != BCX_Q1) begin
			case (phase_ff)
				BCX_Q1: begin
					nxt_phase = BCX_Q2;
					if (!nop_ff) begin
						nxt_ir = prog_data;
						nxt_pc = pc_ff + BCX_PC_STEP;
					end
				end
				BCX_Q2: begin
					nxt_phase = BCX_Q3;
					// register address resolved during the read phase
					if (!ir_ff[8]) begin
						if (ctrl_ff[BCX_CTRL_EXT] && ir_ff[7:0] <= BCX_IDX_LAST)
							nxt_daddr = fsr2_ff + {4'h0, ir_ff[7:0]};
						else if (ir_ff[7:0] < BCX_ACC_SPLIT)
							nxt_daddr = {4'h0, ir_ff[7:0]};
						else
							nxt_daddr = {BCX_ACC_HI_BANK, ir_ff[7:0]};
					end else begin
						nxt_daddr = {bsr_ff, ir_ff[7:0]};
					end
				end
				BCX_Q3: begin
					nxt_phase = BCX_Q4;
					if (!nop_ff && is_call) begin
						nxt_tos = pc_ff + BCX_PC_STEP;
						if (ir_ff[8]) begin
							nxt_ws   = w_ff;
							nxt_sts  = st_ff;
							nxt_bank_select_shadow = bsr_ff;
						end
					end
					// strobe stands through q4 so the write lands in that phase
					if (!nop_ff && is_zero_register_instr)
						nxt_dwr = '{we: 1'b1, addr: daddr_ff, data: BCX_CLR_VALUE};
				end
				BCX_Q4: begin
					nxt_phase = BCX_Q1;
					nxt_nop   = 1'b0;
					if (ctrl_ff[BCX_CTRL_WEN]) begin
						nxt_wcnt = wcnt_ff + 8'h01;
						if (wcnt_ff == BCX_WDT_LAST) begin
							nxt_wpost = wpost_ff + 8'h01;
							if (wpost_ff == POST_LAST) begin
								nxt_wpost = 8'h00;
								nxt_exp   = 1'b0;
							end
						end
					end
					if (!nop_ff) begin
						if (taken) begin
							nxt_pc  = pc_ff + offs;
							nxt_nop = 1'b1;
						end else if (is_call && prog_data[15:12] == BCX_OP_CALL2) begin
							nxt_pc  = {prog_data[11:0], ir_ff[7:0], 1'b0};
							nxt_nop = 1'b1;
						end else if (is_zero_register_instr) begin
							nxt_st.zero = 1'b1;
						end else if (is_kick) begin
							// a kick beats a timeout in the same cycle
							nxt_wcnt  = 8'h00;
							nxt_wpost = 8'h00;
							nxt_exp   = 1'b1;
							nxt_slp   = 1'b1;
						end
					end
				end
				default: begin
					nxt_phase = BCX_Q1;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			phase_ff <= BCX_Q1;
			nop_ff   <= 1'b0;
			ir_ff    <= 16'h0000;
			pc_ff    <= BCX_PC_RST;
			tos_ff   <= BCX_PC_RST;
			w_ff     <= 8'h00;
			st_ff    <= '0;
			bsr_ff   <= 4'h0;
			ws_ff    <= 8'h00;
			sts_ff   <= '0;
			bank_select_shadow_ff  <= 4'h0;
			fsr2_ff  <= 12'h000;
			daddr_ff <= 12'h000;
			dwr_ff   <= '0;
			wcnt_ff  <= 8'h00;
			wpost_ff <= 8'h00;
			exp_ff   <= 1'b1;
			slp_ff   <= 1'b1;
			ctrl_ff  <= 3'b000;
		end else if (ce) begin
			phase_ff <= nxt_phase;
			nop_ff   <= nxt_nop;
			ir_ff    <= nxt_ir;
			pc_ff    <= nxt_pc;
			tos_ff   <= nxt_tos;
			w_ff     <= nxt_w;
			st_ff    <= nxt_st;
			bsr_ff   <= nxt_bsr;
			ws_ff    <= nxt_ws;
			sts_ff   <= nxt_sts;
			bank_select_shadow_ff  <= nxt_bank_select_shadow;
			fsr2_ff  <= nxt_fsr2;
			daddr_ff <= nxt_daddr;
			dwr_ff   <= nxt_dwr;
			wcnt_ff  <= nxt_wcnt;
			wpost_ff <= nxt_wpost;
			exp_ff   <= nxt_exp;
			slp_ff   <= nxt_slp;
			ctrl_ff  <= nxt_ctrl;
		end
	end

endmodule // bcx_core

/* src/bcx_pkg.sv */
// bcx_pkg: constants, types and register map of the branch/call/clear executor
// assumes a 32-bit avalon-mm slave port with byte addresses
package bcx_pkg;

	// register byte offsets
	localparam logic [5:0] BCX_REG_CTRL   = 6'h00;
	localparam logic [5:0] BCX_REG_PC     = 6'h04;
	localparam logic [5:0] BCX_REG_W      = 6'h08;
	localparam logic [5:0] BCX_REG_STATUS = 6'h0C;
	localparam logic [5:0] BCX_REG_BSR    = 6'h10;
	localparam logic [5:0] BCX_REG_SHADOW = 6'h14;
	localparam logic [5:0] BCX_REG_TOS    = 6'h18;
	localparam logic [5:0] BCX_REG_WDT    = 6'h1C;
	localparam logic [5:0] BCX_REG_FSR2   = 6'h20;
	localparam logic [5:0] BCX_REG_PHASE  = 6'h24;

	// control field positions
	localparam int BCX_CTRL_RUN = 0;
	localparam int BCX_CTRL_EXT = 1;
	localparam int BCX_CTRL_WEN = 2;

	// opcode patterns
	localparam logic [7:0]  BCX_OP_BOV    = 8'hE4;
	localparam logic [7:0]  BCX_OP_BZ     = 8'hE0;
	localparam logic [6:0]  BCX_OP_CALL   = 7'h76;
	localparam logic [3:0]  BCX_OP_CALL2  = 4'hF;
	localparam logic [6:0]  BCX_OP_ZERO_REGISTER_INSTR   = 7'h35;
	localparam logic [15:0] BCX_OP_WATCHDOG_KICK_INSTR = 16'h0004;

	// addressing
	localparam logic [7:0]  BCX_IDX_LAST    = 8'h5F;
	localparam logic [7:0]  BCX_ACC_SPLIT   = 8'h80;
	localparam logic [3:0]  BCX_ACC_HI_BANK = 4'hF;
	localparam logic [7:0]  BCX_CLR_VALUE   = 8'h00;

	// reset values and steps
	localparam logic [20:0] BCX_PC_RST   = 21'h00_0000;
	localparam logic [20:0] BCX_PC_STEP  = 21'h00_0002;
	localparam logic [7:0]  BCX_WDT_LAST = 8'hFF;
	localparam logic [7:0]  BCX_POST_DEF = 8'h0F;

	typedef enum logic [3:0] {
		BCX_Q1 = 4'b0001,
		BCX_Q2 = 4'b0010,
		BCX_Q3 = 4'b0100,
		BCX_Q4 = 4'b1000
	} bcx_phase_t;

	typedef struct packed {
		logic [2:0] rsv;
		logic       neg;
		logic       ovf;
		logic       zero;
		logic       dc;
		logic       carry;
	} bcx_flags_t;

	typedef struct packed {
		logic        we;
		logic [11:0] addr;
		logic [7:0]  data;
	} bcx_dwr_t;

endpackage
